// File: testbench/test_phy_shadow_status_seed_regs.sv
// self-checking bench for the shadow/seed register pair
`timescale 1ns/1ps
`default_nettype none
`include "pssr_cfg.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
   mismatches++; $display("unexpected at %0t: got %h expected %h", \
   $time, got, exp); end end

module test_phy_shadow_status_seed_regs;
   import pssr_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   pssr_phy_stat_t stat = '0;
   pssr_seed_gen_t sgen = '0;
   logic [1:0] mode_select;
   logic [4:0] shadow_sel;
   logic shadow_view;
   logic [10:0] local_seed;
   logic [31:0] rd;
   logic err;
   int mismatches = 0;
   int check_count = 0;
   localparam logic [11:0] MC = 12'(4 * `PSSR_MC_IDX);
   localparam logic [11:0] MS = 12'(4 * `PSSR_MS_IDX);

   always #2 pclk = ~pclk;

   pssr_regs #(.ADDR_W(12)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .phy_stat(stat), .seed_gen(sgen),
      .mode_select(mode_select), .shadow_sel(shadow_sel),
      .shadow_view(shadow_view), .local_seed(local_seed));

   task automatic give_verdict();
      if (mismatches == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // one apb transfer, waits for pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask

   task automatic t_status();
      stat.copper_link <= 1'b1;
      apb(1'b0, MC, 32'h0, 4'hF);
      `CHK(rd, 32'h00007C88)
      stat.copper_link <= 1'b0;
      stat.energy_det <= 1'b1;
      apb(1'b0, MC, 32'h0, 4'hF);
      `CHK(rd, 32'h00007C28)
   endtask

   task automatic t_mode();
      apb(1'b1, MC, 32'hFFFFFC04, 4'hF);
      `CHK(mode_select, 2'h2)
      apb(1'b1, MC, 32'h00007C02, 4'hF);
      `CHK(mode_select, 2'h2)
      apb(1'b1, MC, 32'h0000FF02, 4'h1);
      `CHK(mode_select, 2'h2)
      apb(1'b0, MC, 32'h0, 4'hF);
      `CHK(rd, 32'h00007C2C)
      apb(1'b1, MC, 32'h0000A806, 4'hF);
      `CHK(shadow_sel, 5'h0A)
      `CHK(mode_select, 2'h2)
      apb(1'b0, MC, 32'h0, 4'hF);
      `CHK(rd, 32'h00002800)
      apb(1'b1, MC, 32'h00007C00, 4'hF);
      `CHK(shadow_sel, 5'h1F)
   endtask

   task automatic t_seed();
      stat.lp_repeater <= 1'b1;
      stat.lp_man_en <= 1'b1;
      apb(1'b1, MS, 32'hFFFF7ABC, 4'hF);
      `CHK(local_seed, 11'h2BC)
      apb(1'b0, MS, 32'h0, 4'hF);
      `CHK(rd, 32'h00002ABC)
      stat.lp_repeater <= 1'b0;
      stat.lp_man_master <= 1'b1;
      apb(1'b0, MS, 32'h0, 4'hF);
      `CHK(rd, 32'h00001ABC)
      apb(1'b1, MS, 32'h00008000, 4'hF);
      `CHK(shadow_view, 1'b1)
      `CHK(local_seed, 11'h2BC)
      apb(1'b0, MS, 32'h0, 4'hF);
      `CHK(rd, 32'h00008000)
      apb(1'b1, MS, 32'h00000000, 4'hF);
      `CHK(shadow_view, 1'b0)
      `CHK(local_seed, 11'h000)
   endtask

   task automatic t_match();
      @(posedge pclk);
      stat.seed_match <= 1'b1;
      sgen <= '{seed_load: 1'b1, seed_value: 11'h3C5};
      @(posedge pclk);
      stat.seed_match <= 1'b0;
      sgen.seed_load <= 1'b0;
      @(negedge pclk);
      `CHK(local_seed, 11'h3C5)
      apb(1'b0, MS, 32'h0, 4'hF);
      `CHK(rd, 32'h00005BC5)
      apb(1'b0, MS, 32'h0, 4'hF);
      `CHK(rd, 32'h00001BC5)
   endtask

   task automatic t_unmapped();
      apb(1'b1, 12'h0F0, 32'h00000123, 4'hF);
      `CHK(err, 1'b1)
      `CHK(local_seed, 11'h3C5)
      apb(1'b0, 12'h0F0, 32'h0, 4'hF);
      `CHK(rd, 32'h00000000)
   endtask

   // mid-run reset brings back the defaults
   task automatic t_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK(mode_select, 2'h0)
      `CHK(shadow_sel, 5'h1F)
      `CHK(shadow_view, 1'b0)
      `CHK(local_seed, 11'h000)
      presetn <= 1'b1;
      apb(1'b0, MS, 32'h0, 4'hF);
      `CHK(rd, 32'h00001800)
      `CHK(err, 1'b0)
      apb(1'b0, MC, 32'h0, 4'hF);
      `CHK(rd, 32'h00007C28)
   endtask

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_status();
      t_mode();
      t_seed();
      t_match();
      t_unmapped();
      t_reset();
      give_verdict();
   end

   initial begin
      repeat (5000) @(posedge pclk);
      mismatches++;
      give_verdict();
   end
endmodule
`default_nettype wire

// File: verilog/pssr_cfg.svh
// offsets, field positions, reset values for the shadow/seed register pair
`ifndef PSSR_CFG_SVH
`define PSSR_CFG_SVH
`define PSSR_MC_IDX 8'h38
`define PSSR_MS_IDX 8'h3A
`define PSSR_WE_BIT 15
`define PSSR_SEL_HI 14
`define PSSR_SEL_LO 10
`define PSSR_SEL_MODE 5'h1F
`define PSSR_LINK_BIT 7
`define PSSR_ENERGY_BIT 5
`define PSSR_RSV1_BIT 3
`define PSSR_MODE_HI 2
`define PSSR_MODE_LO 1
`define PSSR_VIEW_BIT 15
`define PSSR_MATCH_BIT 14
`define PSSR_RPTR_BIT 13
`define PSSR_LPMST_BIT 12
`define PSSR_LPEN_BIT 11
`define PSSR_SEED_HI 10
`define PSSR_SEL_RST 5'h1F
`define PSSR_MODE_RST 2'h0
`define PSSR_SEED_RST 11'h000
`define PSSR_VIEW_VAL 16'h8000
`endif

// File: verilog/pssr_pkg.sv
// types for the shadow/seed register pair
package pssr_pkg;
   typedef struct packed {
      logic copper_link;
      logic energy_det;
      logic lp_repeater;
      logic lp_man_master;
      logic lp_man_en;
      logic seed_match;
   } pssr_phy_stat_t;

   typedef struct packed {
      logic seed_load;
      logic [10:0] seed_value;
   } pssr_seed_gen_t;

   typedef struct packed {
      logic [4:0] sel;
      logic [1:0] mode;
      logic view;
      logic [10:0] seed;
      logic match;
      logic [15:0] rdata;
   } pssr_state_t;
endpackage

// File: verilog/pssr_regs.sv
// mode control shadow and master/slave seed registers behind an apb slave
// Notes on behaviour
// - at 0x38 bit 15 high writes the mode select bits 2:1, low only selects a shadow to read back.
// - accesses at 0x38 reach the mode control shadow when the selector bits 14:10 hold 11111.
// - read-only bit 7 of the mode control shadow shows the copper link as good (1) or down (0).
// - read-only bit 5 of the mode control shadow shows energy detected on the copper interface.
// - at 0x3A bit 15 written high selects the shadow view, low keeps the seed register view.
// - a write to the register chosen at 0x3A completes in a single access cycle.
// - seed register bit 14 is a read-only latched-high flag for a local/partner seed match.
// - seed register bit 13 reads one for a repeater or switch partner, zero for an end station.
// - seed register bit 12 shows the partner manual role, one for master, zero for slave.
// - seed register bit 11 shows whether partner manual role configuration is enabled.
// - seed register bits 10:0 are read-write, reset to zero, and return the local random seed.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pssr_cfg.svh"

module pssr_regs #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // phy status and seed generator
   input wire pssr_pkg::pssr_phy_stat_t phy_stat,
   input wire pssr_pkg::pssr_seed_gen_t seed_gen,
   // control towards the phy
   output logic [1:0] mode_select,
   output logic [4:0] shadow_sel,
   output logic shadow_view,
   output logic [10:0] local_seed
);
   import pssr_pkg::*;

   localparam logic [ADDR_W-1:0] MC_ADDR = ADDR_W'({`PSSR_MC_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] MS_ADDR = ADDR_W'({`PSSR_MS_IDX, 2'b00});

   // both register addresses need ten address bits
   if (ADDR_W < 10) begin : g_addr_check
      $error("pssr_regs: ADDR_W must be at least 10");
   end

   pssr_state_t q_ff;
   pssr_state_t nxt_q;

   logic hit_mc;
   logic hit_ms;
   logic setup;
   logic acc;
   logic [15:0] wmask;
   logic [15:0] mc_cur;
   logic [15:0] ms_cur;
   logic [15:0] mc_w;
   logic [15:0] ms_w;

   assign hit_mc = (paddr == MC_ADDR);
   assign hit_ms = (paddr == MS_ADDR);
   assign setup = psel & ~penable;
   assign acc = psel & penable;
   assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   // zero wait states
   assign pready = 1'b1;
   assign pslverr = acc & ~hit_mc & ~hit_ms;
   assign prdata = {16'h0000, q_ff.rdata};
   assign mode_select = q_ff.mode;
   assign shadow_sel = q_ff.sel;
   assign shadow_view = q_ff.view;
   assign local_seed = q_ff.seed;

   always_comb begin
      // current read view of 0x38; write enable reads back zero
      mc_cur = 16'h0000;
      mc_cur[`PSSR_SEL_HI:`PSSR_SEL_LO] = q_ff.sel;
      if (q_ff.sel == `PSSR_SEL_MODE) begin
         mc_cur[`PSSR_LINK_BIT] = phy_stat.copper_link;
         mc_cur[`PSSR_ENERGY_BIT] = phy_stat.energy_det;
         mc_cur[`PSSR_RSV1_BIT] = 1'b1;
         mc_cur[`PSSR_MODE_HI:`PSSR_MODE_LO] = q_ff.mode;
      end
      // current read view of 0x3A; shadow view holds only its select bit
      if (q_ff.view) begin
         ms_cur = `PSSR_VIEW_VAL;
      end else begin
         ms_cur = 16'h0000;
         ms_cur[`PSSR_MATCH_BIT] = q_ff.match;
         ms_cur[`PSSR_RPTR_BIT] = phy_stat.lp_repeater;
         ms_cur[`PSSR_LPMST_BIT] = phy_stat.lp_man_master;
         ms_cur[`PSSR_LPEN_BIT] = phy_stat.lp_man_en;
         ms_cur[`PSSR_SEED_HI:0] = q_ff.seed;
      end
      // disabled byte lanes keep the current value
      mc_w = (pwdata[15:0] & wmask) | (mc_cur & ~wmask);
      ms_w = (pwdata[15:0] & wmask) | (ms_cur & ~wmask);

      nxt_q = q_ff;
      // read data captured in the setup cycle
      if (setup) begin
         if (pwrite) begin
            nxt_q.rdata = 16'h0000;
         end else if (hit_mc) begin
            nxt_q.rdata = mc_cur;
         end else if (hit_ms) begin
            nxt_q.rdata = ms_cur;
         end else begin
            nxt_q.rdata = 16'h0000;
         end
      end

      if (seed_gen.seed_load) begin
         nxt_q.seed = seed_gen.seed_value;
      end

      if (acc && pwrite && hit_mc) begin
         nxt_q.sel = mc_w[`PSSR_SEL_HI:`PSSR_SEL_LO];
         if (mc_w[`PSSR_WE_BIT] &&
             mc_w[`PSSR_SEL_HI:`PSSR_SEL_LO] == `PSSR_SEL_MODE) begin
            nxt_q.mode = mc_w[`PSSR_MODE_HI:`PSSR_MODE_LO];
         end
      end

      // single-cycle write into whichever view bit 15 names
      if (acc && pwrite && hit_ms) begin
         nxt_q.view = ms_w[`PSSR_VIEW_BIT];
         if (!ms_w[`PSSR_VIEW_BIT]) begin
            nxt_q.seed = ms_w[`PSSR_SEED_HI:0];
         end
      end

      // clear only what the read returned; a new match still sets
      if (acc && !pwrite && hit_ms) begin
         nxt_q.match = q_ff.match & ~q_ff.rdata[`PSSR_MATCH_BIT];
      end
      if (phy_stat.seed_match) begin
         nxt_q.match = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_ff <= '{sel: `PSSR_SEL_RST, mode: `PSSR_MODE_RST, view: 1'b0,
                   seed: `PSSR_SEED_RST, match: 1'b0, rdata: 16'h0000};
      end else begin
         q_ff <= nxt_q;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_zero_wait: assert property (
      acc |-> pready && !$past(acc))
      else $error("access phase longer than one cycle");

   a_mode_write: assert property (
      acc && pwrite && hit_mc && pstrb[1:0] == 2'h3 && pwdata[15] &&
      pwdata[14:10] == 5'h1F |=> mode_select == $past(pwdata[2:1]))
      else $error("mode select not written");

   a_select_only: assert property (
      acc && pwrite && hit_mc && pstrb[1:0] == 2'h3 && !pwdata[15]
      |=> $stable(mode_select) && shadow_sel == $past(pwdata[14:10]))
      else $error("select-only access changed payload");

   a_other_shadow: assert property (
      setup && !pwrite && hit_mc && shadow_sel != 5'h1F
      |=> prdata[9:0] == 10'h000)
      else $error("payload shown for unselected shadow");

   a_link_read: assert property (
      setup && !pwrite && hit_mc && shadow_sel == 5'h1F
      |=> prdata[7] == $past(phy_stat.copper_link))
      else $error("copper link bit wrong");

   a_energy_read: assert property (
      setup && !pwrite && hit_mc && shadow_sel == 5'h1F
      |=> prdata[5] == $past(phy_stat.energy_det))
      else $error("energy detect bit wrong");

   a_view_write: assert property (
      acc && pwrite && hit_ms && pstrb[1]
      |=> shadow_view == $past(pwdata[15]))
      else $error("shadow view bit not written");

   a_match_latch: assert property (
      phy_stat.seed_match |=> q_ff.match [*1] ##1 (q_ff.match ||
      $past(acc && !pwrite && hit_ms)))
      else $error("seed match event lost");

   a_repeater_read: assert property (
      setup && !pwrite && hit_ms && !shadow_view
      |=> prdata[13] == $past(phy_stat.lp_repeater))
      else $error("partner repeater bit wrong");

   a_lp_master: assert property (
      setup && !pwrite && hit_ms && !shadow_view
      |=> prdata[12] == $past(phy_stat.lp_man_master))
      else $error("partner role bit wrong");

   a_lp_enable: assert property (
      setup && !pwrite && hit_ms && !shadow_view
      |=> prdata[11] == $past(phy_stat.lp_man_en))
      else $error("partner manual enable bit wrong");

   a_seed_write: assert property (
      acc && pwrite && hit_ms && pstrb[1:0] == 2'h3 && !pwdata[15]
      |=> local_seed == $past(pwdata[10:0]) ##1 prdata[31:16] == 16'h0000)
      else $error("seed not written");

   a_reserved_zero: assert property (
      setup && !pwrite && hit_mc && shadow_sel == 5'h1F
      |=> prdata[3] && prdata[15] == 1'b0 && prdata[9:8] == 2'h0 &&
      prdata[6] == 1'b0 && prdata[4] == 1'b0 && prdata[0] == 1'b0)
      else $error("reserved bits of mode shadow wrong");

   // bus framing and unmapped space

   a_ready_high: assert property (
      pready)
      else $error("pready dropped");

   a_upper_zero: assert property (
      prdata[31:16] == 16'h0000)
      else $error("upper read data not zero");

   a_unmapped_err: assert property (
      pslverr == (acc && paddr != MC_ADDR && paddr != MS_ADDR))
      else $error("slave error does not match address map");

   a_unmapped_hold: assert property (
      acc && pwrite && paddr != MC_ADDR && paddr != MS_ADDR
      |=> $stable(mode_select) && $stable(shadow_sel) && $stable(shadow_view)
      && ($stable(local_seed) || $past(seed_gen.seed_load)))
      else $error("unmapped write changed a register");

   a_unmapped_read: assert property (
      setup && !pwrite && paddr != MC_ADDR && paddr != MS_ADDR
      |=> prdata == 32'h00000000)
      else $error("unmapped read not zero");

   // writes and read-back of the mode control shadow

   a_mode_guard: assert property (
      acc && pwrite && hit_mc && pstrb[1:0] == 2'h3 && pwdata[14:10] != 5'h1F
      |=> $stable(mode_select))
      else $error("mode written through another shadow");

   a_lane_keep: assert property (
      acc && pwrite && hit_mc && !pstrb[1]
      |=> $stable(shadow_sel) && $stable(mode_select))
      else $error("disabled upper lane changed the shadow");

   a_sel_read: assert property (
      setup && !pwrite && hit_mc
      |=> prdata[14:10] == $past(shadow_sel) && !prdata[15])
      else $error("selector read back wrong");

   a_mode_read: assert property (
      setup && !pwrite && hit_mc && shadow_sel == 5'h1F
      |=> prdata[2:1] == $past(mode_select) && prdata[14:10] == 5'h1F)
      else $error("mode field read back wrong");

   // seed register views and latched flag

   a_view_read: assert property (
      setup && !pwrite && hit_ms && shadow_view
      |=> prdata == 32'h00008000)
      else $error("shadow view read back wrong");

   a_view_seed_keep: assert property (
      acc && pwrite && hit_ms && pstrb[1] && pwdata[15] &&
      !seed_gen.seed_load |=> $stable(local_seed))
      else $error("shadow view write changed the seed");

   a_match_read: assert property (
      setup && !pwrite && hit_ms && !shadow_view
      |=> prdata[14] == $past(q_ff.match))
      else $error("seed match flag read back wrong");

   a_match_clear: assert property (
      acc && !pwrite && hit_ms && prdata[14] && !phy_stat.seed_match
      |=> !q_ff.match)
      else $error("seed match flag not cleared by read");

   a_seed_read: assert property (
      setup && !pwrite && hit_ms && !shadow_view
      |=> prdata[10:0] == $past(local_seed) && !prdata[15])
      else $error("seed read back wrong");

   a_seed_load: assert property (
      seed_gen.seed_load && !(acc && pwrite && hit_ms)
      |=> local_seed == $past(seed_gen.seed_value))
      else $error("generated seed not loaded");

endmodule

`default_nettype wire
